// ===== common/vcfs_buf_if.sv
`timescale 1ns/100ps
`default_nettype none

interface vcfs_buf_if #(
  parameter int W = 8
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  // Buffer side
  modport store (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );

  // Side that fills and drains the buffer
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data
  );
endinterface

`default_nettype wire

// ===== common/vcfs_pkg.sv
package vcfs_pkg;

  // Clock and frame rates
  localparam int CLK_HZ = 100_000_000;
  localparam int FPS_525 = 30;
  localparam int FPS_625 = 25;

  // Frame period counter width, wide enough for the slower standard
  localparam int FRAME_W = 22;

  // Crosspoint and decoder sizes
  localparam int N_IN = 16;
  localparam int N_DEC = 4;
  localparam int IN_W = 4;
  localparam int DEC_W = 2;

  // Frame starts a decoder needs after a reroute before it is locked
  localparam logic [1:0] LOCK_FRAMES = 2'h3;
  localparam logic [1:0] LOCK_RST = 2'h0;

  // Caption text store
  localparam int CAP_CHARS = 64;
  localparam int CAP_AW = 6;
  localparam int CHAR_W = 8;
  localparam int COLOR_W = 3;
  localparam int PIX_W = 8;

  // Two-entry command buffer
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;

  // Reset routing: decoder k listens to input number k+1 (index k)
  localparam logic [N_DEC-1:0][IN_W-1:0] ROUTE_RST = {4'h3, 4'h2, 4'h1, 4'h0};

  // Caption color index to overlay luma
  localparam logic [7:0][PIX_W-1:0] CAP_PALETTE = {
    8'hff, 8'hd0, 8'hb0, 8'h90, 8'h70, 8'h50, 8'h30, 8'h10
  };

  // One per-frame command from the host
  typedef struct packed {
    logic cap_on;
    logic [COLOR_W-1:0] color;
    logic [IN_W-1:0] next_in;
    logic [DEC_W-1:0] dec;
  } vcfs_cmd_s;

  localparam int CMD_W = $bits(vcfs_cmd_s);

endpackage

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk = 1'b0, rst = 1'b1, std = 1'b0, use_m = 1'b0, slow = 1'b0, ce = 1'b1;
  logic tb_v = 1'b0, we = 1'b0, done = 1'b0, cpix = 1'b0;
  logic [9:0] tb_d = '0;
  logic [5:0] waddr = '0, raddr = '0;
  logic [7:0] wchar = '0, pix = '0, txt_char, pix_jpeg, pix_bmp;
  logic cmd_valid, cmd_ready, m_valid, irq, go, skip, lock_err, busy, cap_cap;
  logic [9:0] cmd_data, m_data;
  logic [1:0] cap_dec;
  logic [15:0] route;
  logic [3:0] dec_ready;
  int num_errors = 0, compares = 0, cyc = 0;

  // Command source: host model or bench
  assign cmd_valid = use_m ? m_valid : tb_v;
  assign cmd_data = use_m ? m_data : tb_d;

  vcfs_sched #(.FRAME_CYC_525(20), .FRAME_CYC_625(24)) vcfs_sched_inst (
    .I_CLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_STD_625(std),
    .I_CMD_VALID(cmd_valid), .I_CMD_DATA(cmd_data), .O_CMD_READY(cmd_ready),
    .I_TXT_WE(we), .I_TXT_ADDR(waddr), .I_TXT_CHAR(wchar), .I_TXT_RADDR(raddr),
    .O_TXT_CHAR(txt_char), .O_FRAME_IRQ(irq), .O_CAP_GO(go), .O_FRAME_SKIP(skip),
    .O_LOCK_ERR(lock_err), .O_BUSY(busy), .O_CAP_DEC(cap_dec), .O_CAP_CAPTION(cap_cap),
    .I_CAP_DONE(done), .O_ROUTE(route), .O_DEC_READY(dec_ready), .I_PIX(pix),
    .I_CHAR_PIX(cpix), .O_PIX_JPEG(pix_jpeg), .O_PIX_BMP(pix_bmp));

  vcfs_host_model vcfs_host_model_inst (.i_clk(clk), .i_en(use_m), .i_slow(slow),
    .i_irq(irq), .i_ready(cmd_ready), .o_valid(m_valid), .o_data(m_data));

  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (irq !== 1'b1 && n < 100);
    check(irq, 1'b1, "frame start");
  endtask

  task automatic push(input logic [9:0] d);
    tick(1);
    tb_v = 1'b1;
    tb_d = d;
    while (cmd_ready !== 1'b1) tick(1);
    tick(1);
    tb_v = 1'b0;
    tb_d = ~d;
  endtask

  task automatic pulse_done();
    done = 1'b1;
    tick(1);
    done = 1'b0;
  endtask

  task automatic t_lock();
    int n;
    check(route, 16'h3210, "reset route");
    check(cmd_ready, 1'b1, "reset room");
    push(10'h200);
    wait_irq(n);
    check(lock_err, 1'b1, "unlocked capture");
    check(go, 1'b0, "unlocked go");
    wait_irq(n);
    check(skip, 1'b1, "no command");
    check(dec_ready, 4'h0, "early ready");
    wait_irq(n);
    check(16'(n), 16'd20, "period 525");
    wait_irq(n);
    check(dec_ready, 4'hf, "locked");
  endtask

  task automatic t_rr();
    int n;
    logic [1:0] d;
    waddr = 6'h05;
    wchar = 8'h41;
    we = 1'b1;
    tick(1);
    we = 1'b0;
    raddr = 6'h05;
    use_m = 1'b1;
    wait_irq(n);
    check(skip, 1'b1, "empty queue");
    for (int i = 0; i < 8; i++) begin
      d = 2'(i);
      slow = (i > 3);
      wait_irq(n);
      check(go, 1'b1, "go");
      check(cap_dec, d, "decoder");
      check(cap_cap, 1'b1, "caption on");
      pix = 8'h40;
      cpix = 1'b1;
      tick(1);
      if (i == 0) check(txt_char, 8'h41, "caption text");
      check(pix_jpeg, vcfs_pkg::CAP_PALETTE[{1'b0, d}], "overlay");
      check(pix_bmp, 8'h40, "bitmap");
      cpix = 1'b0;
      pulse_done();
      check(busy, 1'b0, "busy");
      check(route[4*d +: 4], 4'(d + 4 * (i / 4 + 1)), "reroute");
      check(dec_ready[d], 1'b0, "relock");
    end
  endtask

  task automatic t_buf();
    int n;
    use_m = 1'b0;
    repeat (4) wait_irq(n);
    check(skip, 1'b1, "idle skip");
    push(10'h025);
    push(10'h02a);
    check(cmd_ready, 1'b0, "buffer full");
    wait_irq(n);
    check(cap_dec, 2'h1, "first out");
    check(cap_cap, 1'b0, "caption off");
    pix = 8'h5a;
    cpix = 1'b1;
    tick(1);
    check(pix_jpeg, 8'h5a, "no overlay when off");
    cpix = 1'b0;
    wait_irq(n);
    check(skip, 1'b1, "busy skip");
    pulse_done();
    wait_irq(n);
    check(cap_dec, 2'h2, "second out");
    check(go, 1'b1, "queued go");
    pulse_done();
    std = 1'b1;
    wait_irq(n);
    wait_irq(n);
    check(16'(n), 16'd24, "period 625");
  endtask

  // Enable low freezes all state, the frame count resumes where it stopped
  task automatic t_ce();
    int n;
    ce = 1'b0;
    tick(30);
    check(irq, 1'b1, "frozen pulse");
    check(route, 16'hba98, "frozen route");
    ce = 1'b1;
    wait_irq(n);
    check(16'(n), 16'd24, "period after freeze");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_lock();
    t_rr();
    t_buf();
    t_ce();
    give_verdict();
  end
endmodule

`default_nettype wire

// ===== dv/vcfs_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module vcfs_host_model (
  // Clock and mode
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_slow,
  // Device side
  input wire logic i_irq,
  input wire logic i_ready,
  output logic o_valid,
  output logic [vcfs_pkg::CMD_W-1:0] o_data
);
  logic [1:0] dec;
  logic [3:0] inp [4];

  // One command per frame start, decoders in turn, held until taken
  initial begin
    o_valid = 1'b0;
    o_data = '0;
    dec = 2'h0;
    for (int k = 0; k < 4; k++) inp[k] = 4'(k);
    forever begin
      @(posedge i_clk);
      #1;
      if (i_en && i_irq) begin
        repeat (i_slow ? 5 : 0) @(posedge i_clk);
        #1;
        o_valid = 1'b1;
        o_data = {1'b1, 1'b0, dec, inp[dec] + 4'h4, dec};
        while (!i_ready) begin
          @(posedge i_clk);
          #1;
        end
        @(posedge i_clk);
        #1;
        inp[dec] = inp[dec] + 4'h4;
        dec = dec + 2'h1;
        o_valid = 1'b0;
        o_data = ~o_data; // Released bus shows no stale word
      end
    end
  end
endmodule

`default_nettype wire

// ===== verilog/vcfs_sched.sv
// How it works
// - One frame period: 30 or 25 per second
// - Pulse frame-start interrupt at each frame start
// - No command ready at start: skip frame
// - Crosspoint routes sixteen inputs to four decoders
// - Rerouted decoder needs three frames to lock
// - Optional 64-character caption, text bank swapped at each capture start
// - Each capture yields compressed image and bitmap
// - Caption transparent, only on compressed image
`timescale 1ns/100ps
`default_nettype none

module vcfs_sched #(
  parameter int FRAME_CYC_525 = vcfs_pkg::CLK_HZ / vcfs_pkg::FPS_525,
  parameter int FRAME_CYC_625 = vcfs_pkg::CLK_HZ / vcfs_pkg::FPS_625
) (
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  // Video standard: high for 625 lines
  input wire logic I_STD_625,
  // Command stream from host
  input wire logic I_CMD_VALID,
  input wire logic [vcfs_pkg::CMD_W-1:0] I_CMD_DATA,
  output logic O_CMD_READY,
  // Caption text load and read
  input wire logic I_TXT_WE,
  input wire logic [vcfs_pkg::CAP_AW-1:0] I_TXT_ADDR,
  input wire logic [vcfs_pkg::CHAR_W-1:0] I_TXT_CHAR,
  input wire logic [vcfs_pkg::CAP_AW-1:0] I_TXT_RADDR,
  output logic [vcfs_pkg::CHAR_W-1:0] O_TXT_CHAR,
  // Frame events and capture control
  output logic O_FRAME_IRQ,
  output logic O_CAP_GO,
  output logic O_FRAME_SKIP,
  output logic O_LOCK_ERR,
  output logic O_BUSY,
  output logic [vcfs_pkg::DEC_W-1:0] O_CAP_DEC,
  output logic O_CAP_CAPTION,
  input wire logic I_CAP_DONE,
  // Crosspoint and decoder lock state
  output logic [vcfs_pkg::N_DEC*vcfs_pkg::IN_W-1:0] O_ROUTE,
  output logic [vcfs_pkg::N_DEC-1:0] O_DEC_READY,
  // Pixel path: caption overlay on compressed path only
  input wire logic [vcfs_pkg::PIX_W-1:0] I_PIX,
  input wire logic I_CHAR_PIX,
  output logic [vcfs_pkg::PIX_W-1:0] O_PIX_JPEG,
  output logic [vcfs_pkg::PIX_W-1:0] O_PIX_BMP
);

  typedef struct packed {
    logic [vcfs_pkg::FRAME_W-1:0] frame_cnt;
    logic irq;
    logic go;
    logic skip;
    logic lock_err;
    logic busy;
    vcfs_pkg::vcfs_cmd_s cur;
    logic [vcfs_pkg::N_DEC-1:0][vcfs_pkg::IN_W-1:0] route;
    logic [vcfs_pkg::N_DEC-1:0][1:0] lock;
    logic [vcfs_pkg::N_DEC-1:0] ready;
    logic bank;
    logic [1:0][vcfs_pkg::CAP_CHARS-1:0][vcfs_pkg::CHAR_W-1:0] text;
    logic [vcfs_pkg::CHAR_W-1:0] txt_rd;
    logic [vcfs_pkg::PIX_W-1:0] pix_jpeg;
    logic [vcfs_pkg::PIX_W-1:0] pix_bmp;
  } vcfs_sched_s;

  localparam vcfs_sched_s RST_STATE = '{route: vcfs_pkg::ROUTE_RST, default: '0};
  localparam logic [vcfs_pkg::FRAME_W-1:0] LAST_525 =
    vcfs_pkg::FRAME_W'(FRAME_CYC_525 - 1);
  localparam logic [vcfs_pkg::FRAME_W-1:0] LAST_625 =
    vcfs_pkg::FRAME_W'(FRAME_CYC_625 - 1);

  vcfs_sched_s q;
  vcfs_sched_s d;
  logic start;
  logic take;
  vcfs_pkg::vcfs_cmd_s head;

  vcfs_buf_if #(.W(vcfs_pkg::CMD_W)) cmd_bus ();

  // Two-entry command buffer between host and scheduler
  vcfs_skid #(.W(vcfs_pkg::CMD_W)) u_cmd_buf (
    .i_clk (I_CLK),
    .i_rst (I_SYS_RST),
    .i_ce (I_CE),
    .bus (cmd_bus.store)
  );

  // Host side of the buffer and its head word
  assign cmd_bus.in_valid = I_CMD_VALID;
  assign cmd_bus.in_data = I_CMD_DATA;
  assign head = cmd_bus.out_data;
  // A command leaves the buffer only at a frame start with no capture running
  // Compare at or past the end, so a switch to the shorter standard never overruns
  assign start = (q.frame_cnt >= (I_STD_625 ? LAST_625 : LAST_525));
  assign take = start && !q.busy;
  assign cmd_bus.out_ready = take;

  // Frame timing, command dispatch, reroute and caption store
  always_comb begin
    d = q;
    d.irq = 1'b0;
    d.go = 1'b0;
    d.skip = 1'b0;
    d.lock_err = 1'b0;
    d.frame_cnt = start ? '0 : q.frame_cnt + 1'b1;
    if (start) begin
      d.irq = 1'b1;
      for (int k = 0; k < vcfs_pkg::N_DEC; k++) begin
        if (q.lock[k] != vcfs_pkg::LOCK_FRAMES) begin
          d.lock[k] = q.lock[k] + 2'h1;
        end
      end
      if (take && cmd_bus.out_valid && q.ready[head.dec]) begin
        d.go = 1'b1;
        d.busy = 1'b1;
        d.cur = head;
        d.bank = ~q.bank;
      end else begin
        d.skip = 1'b1;
        d.lock_err = take && cmd_bus.out_valid;
      end
    end
    // Capture finished: switch that decoder, restart its lock wait
    if (I_CAP_DONE && q.busy) begin
      d.busy = 1'b0;
      d.route[q.cur.dec] = q.cur.next_in;
      d.lock[q.cur.dec] = vcfs_pkg::LOCK_RST;
    end
    for (int k = 0; k < vcfs_pkg::N_DEC; k++) begin
      d.ready[k] = (d.lock[k] == vcfs_pkg::LOCK_FRAMES);
    end
    // Host fills the idle bank while the other one is shown
    if (I_TXT_WE) begin
      d.text[~q.bank][I_TXT_ADDR] = I_TXT_CHAR;
    end
    d.txt_rd = q.text[q.bank][I_TXT_RADDR];
    // Transparent caption on the compressed path, bitmap untouched
    d.pix_bmp = I_PIX;
    if (q.cur.cap_on && I_CHAR_PIX) begin
      d.pix_jpeg = vcfs_pkg::CAP_PALETTE[q.cur.color];
    end else begin
      d.pix_jpeg = I_PIX;
    end
  end

  // State register
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      q <= RST_STATE;
    end else if (I_CE) begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign O_CMD_READY = cmd_bus.in_ready;
  assign O_TXT_CHAR = q.txt_rd;
  assign O_FRAME_IRQ = q.irq;
  assign O_CAP_GO = q.go;
  assign O_FRAME_SKIP = q.skip;
  assign O_LOCK_ERR = q.lock_err;
  assign O_BUSY = q.busy;
  assign O_CAP_DEC = q.cur.dec;
  assign O_CAP_CAPTION = q.cur.cap_on;
  assign O_ROUTE = q.route;
  assign O_DEC_READY = q.ready;
  assign O_PIX_JPEG = q.pix_jpeg;
  assign O_PIX_BMP = q.pix_bmp;

  // Cycles since the last frame start, for the period check
  logic [vcfs_pkg::FRAME_W-1:0] gap_q;
  logic seen_q;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (I_CE) begin
      gap_q <= O_FRAME_IRQ ? vcfs_pkg::FRAME_W'(1) : gap_q + 1'b1;
      seen_q <= seen_q | O_FRAME_IRQ;
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  sequence s_frame_go;
    O_FRAME_IRQ && O_CAP_GO;
  endsequence

  sequence s_reroute;
    I_CE && I_CAP_DONE && O_BUSY;
  endsequence

  a_frame_period: assert property (O_FRAME_IRQ && seen_q && $past(I_CE)
    |-> gap_q == (I_STD_625 ? LAST_625 + 1'b1 : LAST_525 + 1'b1))
    else $error("frame start spacing differs from the frame period");
  a_irq_pulse: assert property (O_FRAME_IRQ && I_CE |=> !O_FRAME_IRQ)
    else $error("frame start pulse longer than one cycle");
  a_go_or_skip: assert property (O_FRAME_IRQ |-> (O_CAP_GO ^ O_FRAME_SKIP))
    else $error("frame start neither captured nor skipped exactly once");
  a_go_ready: assert property (s_frame_go |-> O_DEC_READY[O_CAP_DEC])
    else $error("capture started on an unlocked decoder");
  a_reroute_lock: assert property (s_reroute |=> !O_BUSY &&
    !O_DEC_READY[$past(O_CAP_DEC)])
    else $error("rerouted decoder still marked ready");
  a_ready_rise: assert property ((O_DEC_READY & ~$past(O_DEC_READY)) != '0
    |-> O_FRAME_IRQ)
    else $error("decoder became ready outside a frame start");
  a_route_cause: assert property (O_ROUTE != $past(O_ROUTE)
    |-> $past(I_CAP_DONE && O_BUSY))
    else $error("crosspoint changed without a finished capture");
  a_bmp_clean: assert property ($past(I_CE) |-> O_PIX_BMP == $past(I_PIX))
    else $error("bitmap pixel altered");
  a_caption_only: assert property ($past(I_CE) &&
    !$past(O_CAP_CAPTION && I_CHAR_PIX) |-> O_PIX_JPEG == $past(I_PIX))
    else $error("compressed pixel altered without caption");

endmodule

`default_nettype wire

// ===== verilog/vcfs_skid.sv
`timescale 1ns/100ps
`default_nettype none

module vcfs_skid #(
  parameter int W = 8
) (
  // Clock, reset and enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Buffer ports
  vcfs_buf_if.store bus
);

  typedef struct packed {
    logic [vcfs_pkg::BUF_DEPTH-1:0][W-1:0] mem;
    logic [1:0] cnt;
    logic rdy;
  } vcfs_skid_s;

  localparam vcfs_skid_s RST_STATE = '{rdy: 1'b1, default: '0};

  vcfs_skid_s q;
  vcfs_skid_s d;
  logic push;
  logic pop;

  // Ready and head word come from state
  assign bus.in_ready = q.rdy;
  assign bus.out_valid = (q.cnt != 2'h0);
  assign bus.out_data = q.mem[0];

  // Pop shifts the head out, push lands behind what remains
  always_comb begin
    d = q;
    push = bus.in_valid && q.rdy;
    pop = bus.out_ready && (q.cnt != 2'h0);
    if (pop) begin
      d.mem[0] = q.mem[1];
      d.cnt = q.cnt - 2'h1;
    end
    if (push) begin
      d.mem[d.cnt[0]] = bus.in_data;
      d.cnt = d.cnt + 2'h1;
    end
    d.rdy = (d.cnt != vcfs_pkg::BUF_FULL);
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= RST_STATE;
    end else if (i_ce) begin
      q <= d;
    end
  end

endmodule

`default_nettype wire
